// *** dv/flc_flash_model.sv ***
// Behavioural flash device answering the host strobes with status or array data
`timescale 1ns/100ps
module flc_flash_model #(
  parameter int PROG_CYC = 100,
  parameter int WIN_CYC = 200,
  parameter int ERASE_CYC = 400,
  parameter int FAIL_CYC = 150
) (
  input wire logic clk,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [flc_pkg::ADDR_W-1:0] a,
  input wire logic [flc_pkg::DATA_W-1:0] dq_o,
  output logic [flc_pkg::DATA_W-1:0] dq,
  output logic rb_n
);
  typedef enum logic [2:0] {FM_RD, FM_PROG, FM_WIN, FM_ERASE, FM_FAIL, FM_SUSP, FM_SPROG} flc_fm_t;
  flc_fm_t st = FM_RD;
  logic [15:0] mem [16];
  logic [15:0] pdat = '0, rd_q = '0;
  logic [1:0] esec = '0;
  logic we_q = '1, oe_q = '1, tog1 = '0, tog2 = '0, fail = '0;
  int cnt = 0, pcnt = 0;
  initial foreach (mem[i]) mem[i] = 16'hFFFF;
  // Busy pin pulled up when idle or suspended; a released bus shows the inverted last value
  assign rb_n = (st == FM_RD) || (st == FM_SUSP);
  assign dq = (!ce_n && !oe_n) ? rd_q : ~rd_q;
  ////////////////////////////////////////////////////////////
  // Timers, command writes and read cycles
  always @(posedge clk) begin
    we_q <= we_n;
    oe_q <= oe_n;
    // Erase timer frozen while suspended; own timer for suspend-program
    if (cnt > 0 && st != FM_SUSP && st != FM_SPROG) cnt <= cnt - 1;
    if (pcnt > 0) pcnt <= pcnt - 1;
    if (pcnt == 1) st <= FM_SUSP;
    if (cnt == 1) begin
      case (st)
        FM_PROG: st <= FM_RD;
        FM_WIN: begin
          st <= FM_ERASE;
          cnt <= ERASE_CYC;
        end
        FM_ERASE: begin
          foreach (mem[i]) mem[i] <= 16'hFFFF;
          st <= FM_RD;
        end
        FM_FAIL: fail <= '1;
        default: ;
      endcase
    end
    if (we_n && !we_q && !ce_n) begin
      case (st)
        FM_RD: begin
          pdat <= dq_o;
          esec <= a[3:2];
          cnt <= (dq_o == 16'h30) ? WIN_CYC : (dq_o == 16'h10) ? ERASE_CYC : PROG_CYC;
          if (dq_o == 16'h30) st <= FM_WIN;
          else if (dq_o == 16'h10) st <= FM_ERASE;
          else if ((dq_o & ~mem[a[3:0]]) != 16'h0) begin
            st <= FM_FAIL;
            cnt <= FAIL_CYC;
          end else begin
            mem[a[3:0]] <= dq_o;
            st <= FM_PROG;
          end
        end
        FM_WIN: if (dq_o == 16'h30) cnt <= WIN_CYC;
        FM_ERASE: if (dq_o == 16'hB0) st <= FM_SUSP; // Only suspend accepted
        FM_SUSP: begin
          if (dq_o == 16'h30) st <= FM_ERASE;
          else begin
            mem[a[3:0]] <= dq_o;
            pdat <= dq_o;
            pcnt <= PROG_CYC;
            st <= FM_SPROG;
          end
        end
        FM_FAIL: if (dq_o == 16'hF0) begin
          st <= FM_RD;
          fail <= '0;
          cnt <= 0;
        end
        default: ;
      endcase
    end
    if (!oe_n && oe_q && !ce_n) begin
      if (st == FM_RD || (st == FM_SUSP && a[3:2] != esec)) rd_q <= mem[a[3:0]];
      else begin
        rd_q <= {8'h0, (st == FM_SUSP) | ((st == FM_PROG || st == FM_FAIL || st == FM_SPROG) & ~pdat[7]),
          tog1, fail, 1'h0, st == FM_ERASE, (st == FM_WIN || st == FM_ERASE || st == FM_SUSP) & tog2, 2'h0};
        tog1 <= tog1 ^ (st != FM_SUSP);
        tog2 <= tog2 ^ (st == FM_WIN || st == FM_ERASE || st == FM_SUSP);
      end
    end
  end
endmodule

// *** dv/flc_host_props.sv ***
// Checker for the controller's bus handshakes and flash strobe timing
`timescale 1ns/100ps
module flc_host_props (
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic [1:0] BRESP,
  input wire logic RVALID,
  input wire logic RREADY,
  input wire logic [31:0] RDATA,
  input wire logic FL_CE_N,
  input wire logic FL_OE_N,
  input wire logic FL_WE_N,
  input wire logic [flc_pkg::ADDR_W-1:0] FL_A,
  input wire logic FL_DQ_OE
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  ////////////////////////////////////////////////////////////
  // Register bus handshakes
  aw_w_pair_a: assert property (AWREADY |-> WREADY && AWVALID && WVALID) else $error("write ready without both valids");
  aw_pulse_a: assert property (AWREADY |=> !AWREADY) else $error("write ready held too long");
  b_answer_a: assert property (AWREADY && AWVALID && WVALID |=> BVALID) else $error("write answer missing");
  b_hold_a: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP)) else $error("write answer dropped");
  r_hold_a: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA)) else $error("read answer dropped");
  ////////////////////////////////////////////////////////////
  // Flash strobes
  strobe_excl_a: assert property (!(!FL_OE_N && !FL_WE_N)) else $error("both strobes low");
  read_free_a: assert property (!FL_OE_N |-> !FL_DQ_OE && !FL_CE_N) else $error("data driven in read");
  we_width_a: assert property ($fell(FL_WE_N) |-> ##9 !FL_WE_N ##1 FL_WE_N) else $error("write pulse width wrong");
  addr_hold_a: assert property (!FL_CE_N && !$past(FL_CE_N) |-> $stable(FL_A)) else $error("address moved");
  // Main scenarios
  cover property (BVALID && BRESP == flc_pkg::RESP_SLVERR);
  cover property ($fell(FL_OE_N));
  cover property ($fell(FL_WE_N));
endmodule

bind flc_host flc_host_props u_props (.REF_CLK(REF_CLK), .RST_B(RST_B), .AWVALID(AWVALID), .AWREADY(AWREADY),
  .WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP), .RVALID(RVALID),
  .RREADY(RREADY), .RDATA(RDATA), .FL_CE_N(FL_CE_N), .FL_OE_N(FL_OE_N), .FL_WE_N(FL_WE_N), .FL_A(FL_A),
  .FL_DQ_OE(FL_DQ_OE));

// *** dv/tb.sv ***
// Bench for the flash status-polling controller against a behavioural flash
`timescale 1ns/100ps
module tb;
  typedef struct packed {logic wr; logic [7:0] ad; logic [31:0] d; logic [1:0] rsp;} flc_row_t;
  logic REF_CLK = '0, RST_B = '0, AWVALID = '0, WVALID = '0, BREADY = '0, ARVALID = '0, RREADY = '0;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ, FL_CE_N, FL_OE_N, FL_WE_N, FL_DQ_OE, FL_READY_BUSY_N;
  logic [7:0] AWADDR = '0, ARADDR = '0;
  logic [31:0] WDATA = '0, RDATA, d;
  logic [1:0] BRESP, RRESP, r;
  logic [flc_pkg::ADDR_W-1:0] FL_A;
  logic [flc_pkg::DATA_W-1:0] FL_DQ_I, FL_DQ_O;
  logic [2:0] mask_v = '0;
  int n_fail = 0, checks_done = 0, cyc = 0;
  flc_row_t rows [9] = '{'{1'h0, 8'h14, 32'h0, 2'h0}, '{1'h0, 8'h18, 32'h0, 2'h0}, '{1'h0, 8'h10, 32'h0, 2'h0},
    '{1'h1, 8'h14, 32'h7, 2'h0}, '{1'h0, 8'h14, 32'h7, 2'h0}, '{1'h1, 8'h18, 32'hF0, 2'h0},
    '{1'h0, 8'h18, 32'hF0, 2'h0}, '{1'h1, 8'h1C, 32'h5, 2'h2}, '{1'h0, 8'h1C, 32'h0, 2'h2}};
  flc_host dut (.REF_CLK(REF_CLK), .RST_B(RST_B), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WDATA(WDATA), .WSTRB(4'hF), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
    .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
    .RVALID(RVALID), .RREADY(RREADY), .IRQ(IRQ), .FL_CE_N(FL_CE_N), .FL_OE_N(FL_OE_N), .FL_WE_N(FL_WE_N),
    .FL_A(FL_A), .FL_DQ_I(FL_DQ_I), .FL_DQ_O(FL_DQ_O), .FL_DQ_OE(FL_DQ_OE), .FL_READY_BUSY_N(FL_READY_BUSY_N));
  flc_flash_model u_flash (.clk(REF_CLK), .ce_n(FL_CE_N), .oe_n(FL_OE_N), .we_n(FL_WE_N), .a(FL_A),
    .dq_o(FL_DQ_O), .dq(FL_DQ_I), .rb_n(FL_READY_BUSY_N));
  // Clock and a cycle ceiling that cuts a hang short
  always #2.5 REF_CLK = ~REF_CLK;
  always @(posedge REF_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_fail++;
      print_verdict;
    end
  end
  ////////////////////////////////////////////////////////////
  // Verdict, comparison and bus tasks
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic axi_wr(input logic [7:0] ad, input logic [31:0] v);
    AWADDR <= ad;
    WDATA <= v;
    AWVALID <= '1;
    WVALID <= '1;
    do @(posedge REF_CLK); while (AWREADY !== '1);
    AWVALID <= '0;
    WVALID <= '0;
    BREADY <= '1;
    do @(posedge REF_CLK); while (BVALID !== '1);
    r = BRESP;
    BREADY <= '0;
  endtask
  task automatic axi_rd(input logic [7:0] ad);
    ARADDR <= ad;
    ARVALID <= '1;
    do @(posedge REF_CLK); while (ARREADY !== '1);
    ARVALID <= '0;
    RREADY <= '1;
    do @(posedge REF_CLK); while (RVALID !== '1);
    d = RDATA;
    r = RRESP;
    RREADY <= '0;
  endtask
  // Start an operation, wait for idle, check status and interrupt, then clear
  task automatic run_op(input logic [2:0] op, input logic [2:0] e);
    axi_wr(8'h00, {29'h0, op});
    repeat (600) begin
      axi_rd(8'h00);
      if (d[8] === '0) break;
    end
    axi_rd(8'h10);
    chk(d, {29'h0, e});
    chk({31'h0, IRQ}, {31'h0, |(e & mask_v)});
    axi_wr(8'h10, 32'h7);
    repeat (2) @(posedge REF_CLK);
    chk({31'h0, IRQ}, 32'h0);
  endtask
  task automatic rd_word(input logic [31:0] e);
    run_op(3'h1, 3'h1);
    axi_rd(8'h0C);
    chk({15'h0, d[16:0]}, e);
  endtask
  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (3) @(posedge REF_CLK);
    RST_B <= '1;
    @(posedge REF_CLK);
    chk({31'h0, FL_CE_N}, 32'h1);
    foreach (rows[i]) begin
      if (rows[i].wr) axi_wr(rows[i].ad, rows[i].d);
      else begin
        axi_rd(rows[i].ad);
        chk(d, rows[i].d);
      end
      chk({30'h0, r}, {30'h0, rows[i].rsp});
    end
    mask_v = 3'h7;
    // Program a word, poll it, read it back
    axi_wr(8'h04, 32'h1);
    axi_wr(8'h08, 32'h1234);
    run_op(3'h0, 3'h1);
    run_op(3'h2, 3'h1);
    rd_word(32'h11234);
    // Setting ones over zeros fails and the reset command recovers
    axi_wr(8'h08, 32'hFFFF);
    run_op(3'h0, 3'h1);
    run_op(3'h2, 3'h2);
    rd_word(32'h11234);
    // Sector erase window restarted by each add, closed once it runs out
    axi_wr(8'h04, 32'h2);
    axi_wr(8'h08, 32'h30);
    run_op(3'h0, 3'h1);
    repeat (3) run_op(3'h3, 3'h1);
    repeat (250) @(posedge REF_CLK);
    run_op(3'h3, 3'h4);
    run_op(3'h2, 3'h1);
    rd_word(32'h1FFFF);
    // Chip erase has no window; suspend it, program outside its sector, resume
    axi_wr(8'h08, 32'h10);
    run_op(3'h0, 3'h1);
    run_op(3'h3, 3'h4);
    axi_wr(8'h08, 32'hB0);
    run_op(3'h0, 3'h1);
    run_op(3'h2, 3'h1);
    axi_rd(8'h0C);
    chk(d & 32'h0001_00A0, 32'h0001_0080);
    axi_wr(8'h04, 32'h5);
    axi_wr(8'h08, 32'h5A5A);
    run_op(3'h0, 3'h1);
    axi_rd(8'h0C);
    chk({31'h0, d[16]}, 32'h0);
    run_op(3'h2, 3'h1);
    rd_word(32'h15A5A);
    axi_wr(8'h04, 32'h2);
    axi_wr(8'h08, 32'h30);
    run_op(3'h0, 3'h1);
    run_op(3'h2, 3'h1);
    // Illegal operation with the interrupt masked
    axi_wr(8'h14, 32'h0);
    mask_v = 3'h0;
    run_op(3'h5, 3'h4);
    // Reset in mid-operation
    axi_wr(8'h00, 32'h0);
    RST_B <= '0;
    repeat (3) @(posedge REF_CLK);
    chk({31'h0, FL_CE_N}, 32'h1);
    RST_B <= '1;
    @(posedge REF_CLK);
    axi_rd(8'h10);
    chk(d, 32'h0);
    print_verdict;
  end
endmodule

// *** hdl/flc_cycle.sv ***
// One flash bus cycle, write or read, with timed strobes and synchronised data
`timescale 1ns/100ps
module flc_cycle (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic req_v,
  input wire flc_pkg::flc_req_t req,
  input wire logic [flc_pkg::DATA_W-1:0] dq_i,
  output flc_pkg::flc_pins_t pins,
  output logic [flc_pkg::DATA_W-1:0] rdata,
  output logic done
);

  typedef enum logic [1:0] {E_IDLE, E_SET, E_PUL, E_HLD} flc_est_t;

  flc_est_t st_q, st_d;
  logic [7:0] cnt_q, cnt_d;
  logic wr_q, wr_d;
  flc_pkg::flc_pins_t pins_q, pins_d;
  logic [flc_pkg::DATA_W-1:0] rdata_q, rdata_d;
  logic done_q, done_d;
  logic [flc_pkg::DATA_W-1:0] dq_s1_q, dq_s2_q;

  ////////////////////////////////////////////////////////////////////////////
  // Strobe sequencer: setup, pulse, hold
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    wr_d = wr_q;
    pins_d = pins_q;
    rdata_d = rdata_q;
    done_d = 1'h0;
    unique case (st_q)
      E_IDLE: begin
        if (req_v) begin
          wr_d = req.wr;
          pins_d.a = req.addr;
          pins_d.ce_n = 1'h0;
          pins_d.dq_o = req.wdata;
          pins_d.dq_oe = req.wr;
          cnt_d = 8'(flc_pkg::SET_CYC - 1);
          st_d = E_SET;
        end
      end
      E_SET: begin
        if (cnt_q == 8'h00) begin
          pins_d.we_n = ~wr_q;
          pins_d.oe_n = wr_q;
          cnt_d = 8'(flc_pkg::PULSE_CYC - 1);
          st_d = E_PUL;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      E_PUL: begin
        if (cnt_q == 8'h00) begin
          pins_d.we_n = 1'h1;
          pins_d.oe_n = 1'h1;
          if (!wr_q) begin
            rdata_d = dq_s2_q; // Sampled at the end of the output-enable pulse
          end
          cnt_d = 8'(flc_pkg::HOLD_CYC - 1);
          st_d = E_HLD;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      E_HLD: begin
        if (cnt_q == 8'h00) begin
          pins_d.ce_n = 1'h1;
          pins_d.dq_oe = 1'h0;
          done_d = 1'h1;
          st_d = E_IDLE;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
    endcase
  end

  // Registers; data pins pass two flip-flops before use
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_q <= E_IDLE;
      cnt_q <= 8'h00;
      wr_q <= 1'h0;
      pins_q <= '{ce_n: 1'h1, oe_n: 1'h1, we_n: 1'h1, a: '0, dq_o: '0, dq_oe: 1'h0};
      rdata_q <= '0;
      done_q <= 1'h0;
      dq_s1_q <= '0;
      dq_s2_q <= '0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      wr_q <= wr_d;
      pins_q <= pins_d;
      rdata_q <= rdata_d;
      done_q <= done_d;
      dq_s1_q <= dq_i;
      dq_s2_q <= dq_s1_q;
    end
  end

  assign pins = pins_q;
  assign rdata = rdata_q;
  assign done = done_q;

endmodule

// *** hdl/flc_host.sv ***
// Host-side flash controller: AXI4-Lite registers, status polling and erase-window checks
//
// Register access over AXI4-Lite and the register offsets are this design's own decisions.
`timescale 1ns/100ps

module flc_host (
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic [flc_pkg::AXI_AW-1:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [flc_pkg::AXI_AW-1:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  output logic IRQ,
  output logic FL_CE_N,
  output logic FL_OE_N,
  output logic FL_WE_N,
  output logic [flc_pkg::ADDR_W-1:0] FL_A,
  input wire logic [flc_pkg::DATA_W-1:0] FL_DQ_I,
  output logic [flc_pkg::DATA_W-1:0] FL_DQ_O,
  output logic FL_DQ_OE,
  input wire logic FL_READY_BUSY_N
);

  typedef enum logic [3:0] {S_IDLE, S_WR, S_RD, S_PA, S_PB, S_PC, S_RST, S_EA, S_EB, S_EW, S_EC} flc_st_t;

  localparam int DW = flc_pkg::DATA_W;
  localparam int AW = flc_pkg::ADDR_W;
  localparam int SW = flc_pkg::STAT_W;

  // Bus slave state
  logic awready_q, awready_d, bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic [2:0] op_q, op_d;
  logic [AW-1:0] addr_q, addr_d;
  logic [DW-1:0] wdata_q, wdata_d, rstcmd_q, rstcmd_d;
  logic [SW-1:0] stat_q, stat_d, mask_q, mask_d;
  logic irq_q, irq_d;
  logic rb_s1_q, rb_s2_q;
  logic [31:0] wmask;
  logic wr_hs, rd_hs, go;

  // Sequencer state
  flc_st_t st_q, st_d;
  logic pend_q, pend_d, req_v_q, req_v_d, ewin_q, ewin_d;
  logic [DW-1:0] a_q, a_d, b_q, b_d, last_q, last_d;
  logic [SW-1:0] ev;
  flc_pkg::flc_req_t req;
  flc_pkg::flc_pins_t pins;
  logic [DW-1:0] eng_rdata;
  logic eng_done;

  ////////////////////////////////////////////////////////////////////////////
  // Byte-lane mask from write strobes
  for (genvar i = 0; i < 4; i++) begin : g_strb
    assign wmask[8*i +: 8] = {8{WSTRB[i]}};
  end

  // Handshakes and operation start; a start while busy is ignored
  assign wr_hs = awready_q & AWVALID & WVALID;
  assign rd_hs = arready_q & ARVALID;
  assign go = wr_hs & (AWADDR == flc_pkg::OFS_CTRL) & WSTRB[0] & (st_q == S_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Register file and AXI4-Lite slave, next values
  always_comb begin
    awready_d = AWVALID & WVALID & ~awready_q & ~bvalid_q;
    arready_d = ARVALID & ~arready_q & ~rvalid_q;
    bvalid_d = bvalid_q & ~BREADY;
    rvalid_d = rvalid_q & ~RREADY;
    bresp_d = bresp_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    op_d = op_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    rstcmd_d = rstcmd_q;
    mask_d = mask_q;
    stat_d = stat_q;
    if (wr_hs) begin
      bvalid_d = 1'h1;
      bresp_d = flc_pkg::RESP_OKAY;
      unique case (AWADDR)
        flc_pkg::OFS_CTRL: if (go) op_d = WDATA[2:0];
        flc_pkg::OFS_ADDR: if (st_q == S_IDLE) addr_d = (addr_q & ~wmask[AW-1:0]) | (WDATA[AW-1:0] & wmask[AW-1:0]);
        flc_pkg::OFS_WDATA: if (st_q == S_IDLE) wdata_d = (wdata_q & ~wmask[DW-1:0]) | (WDATA[DW-1:0] & wmask[DW-1:0]);
        flc_pkg::OFS_RDATA: ;
        flc_pkg::OFS_STAT: stat_d = stat_q & ~(WDATA[SW-1:0] & wmask[SW-1:0]);
        flc_pkg::OFS_MASK: mask_d = (mask_q & ~wmask[SW-1:0]) | (WDATA[SW-1:0] & wmask[SW-1:0]);
        flc_pkg::OFS_RSTCMD: rstcmd_d = (rstcmd_q & ~wmask[DW-1:0]) | (WDATA[DW-1:0] & wmask[DW-1:0]);
        default: bresp_d = flc_pkg::RESP_SLVERR;
      endcase
    end
    // Events set after the clear, so a set in the same cycle wins
    stat_d = stat_d | ev;
    if (rd_hs) begin
      rvalid_d = 1'h1;
      rresp_d = flc_pkg::RESP_OKAY;
      rdata_d = 32'h0000_0000;
      unique case (ARADDR)
        flc_pkg::OFS_CTRL: rdata_d = {23'h0, st_q != S_IDLE, 5'h0, op_q};
        flc_pkg::OFS_ADDR: rdata_d = 32'(addr_q);
        flc_pkg::OFS_WDATA: rdata_d = 32'(wdata_q);
        flc_pkg::OFS_RDATA: rdata_d = {14'h0, ewin_q, rb_s2_q, last_q};
        flc_pkg::OFS_STAT: rdata_d = 32'(stat_q);
        flc_pkg::OFS_MASK: rdata_d = 32'(mask_q);
        flc_pkg::OFS_RSTCMD: rdata_d = 32'(rstcmd_q);
        default: rresp_d = flc_pkg::RESP_SLVERR;
      endcase
    end
    irq_d = |(stat_d & mask_d);
  end

  // Register file and bus slave, registers; ready/busy pin synchronised
  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      awready_q <= 1'h0;
      arready_q <= 1'h0;
      bvalid_q <= 1'h0;
      rvalid_q <= 1'h0;
      bresp_q <= flc_pkg::RESP_OKAY;
      rresp_q <= flc_pkg::RESP_OKAY;
      rdata_q <= 32'h0000_0000;
      op_q <= flc_pkg::OP_WRITE;
      addr_q <= '0;
      wdata_q <= '0;
      rstcmd_q <= flc_pkg::RSTV_RSTCMD;
      mask_q <= flc_pkg::RSTV_MASK;
      stat_q <= '0;
      irq_q <= 1'h0;
      rb_s1_q <= 1'h1;
      rb_s2_q <= 1'h1;
    end else begin
      awready_q <= awready_d;
      arready_q <= arready_d;
      bvalid_q <= bvalid_d;
      rvalid_q <= rvalid_d;
      bresp_q <= bresp_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      op_q <= op_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      rstcmd_q <= rstcmd_d;
      mask_q <= mask_d;
      stat_q <= stat_d;
      irq_q <= irq_d;
      rb_s1_q <= FL_READY_BUSY_N;
      rb_s2_q <= rb_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cycle request follows the state that issued it
  always_comb begin
    req.wr = (st_q == S_WR) | (st_q == S_RST) | (st_q == S_EW);
    req.addr = addr_q; // Status is read at the operation's own address
    req.wdata = (st_q == S_RST) ? rstcmd_q : wdata_q;
  end

  // Operation sequencer, next values
  always_comb begin
    st_d = st_q;
    pend_d = pend_q;
    req_v_d = 1'h0;
    a_d = a_q;
    b_d = b_q;
    last_d = last_q;
    ewin_d = ewin_q;
    ev = '0;
    if (st_q != S_IDLE && !pend_q) begin
      req_v_d = 1'h1;
      pend_d = 1'h1;
    end
    unique case (st_q)
      S_IDLE: begin
        if (go) begin
          unique case (WDATA[2:0])
            flc_pkg::OP_WRITE: st_d = S_WR;
            flc_pkg::OP_READ: st_d = S_RD;
            flc_pkg::OP_POLL: st_d = S_PA;
            flc_pkg::OP_ERASE_ADD: st_d = S_EA;
            default: ev[flc_pkg::ST_REJ] = 1'h1;
          endcase
        end
      end
      S_WR: if (eng_done) begin
        st_d = S_IDLE;
        ev[flc_pkg::ST_DONE] = 1'h1;
      end
      S_RD: if (eng_done) begin
        last_d = eng_rdata;
        st_d = S_IDLE;
        ev[flc_pkg::ST_DONE] = 1'h1;
      end
      S_PA: if (eng_done) begin
        a_d = eng_rdata;
        st_d = S_PB;
      end
      S_PB: if (eng_done) begin
        last_d = eng_rdata;
        if (a_q[flc_pkg::TB1_BIT] == eng_rdata[flc_pkg::TB1_BIT]) begin // Steady toggle means finished
          st_d = S_IDLE;
          ev[flc_pkg::ST_DONE] = 1'h1;
        end else if (eng_rdata[flc_pkg::FAIL_BIT]) begin // Timing limit hit
          b_d = eng_rdata;
          st_d = S_PC;
        end else begin
          st_d = S_PA; // Still running: restart the two-read check
        end
      end
      S_PC: if (eng_done) begin
        last_d = eng_rdata;
        if (b_q[flc_pkg::TB1_BIT] == eng_rdata[flc_pkg::TB1_BIT]) begin // Stopped just as the flag rose
          st_d = S_IDLE;
          ev[flc_pkg::ST_DONE] = 1'h1;
        end else begin
          st_d = S_RST; // Still toggling: failed
        end
      end
      S_RST: if (eng_done) begin
        st_d = S_IDLE; // Reset command written
        ev[flc_pkg::ST_FAIL] = 1'h1;
      end
      S_EA: if (eng_done) begin
        a_d = eng_rdata;
        st_d = S_EB;
      end
      S_EB: if (eng_done) begin
        last_d = eng_rdata;
        ewin_d = eng_rdata[flc_pkg::EWIN_BIT];
        // Acceptance by toggling first, then the window flag
        if (a_q[flc_pkg::TB1_BIT] == eng_rdata[flc_pkg::TB1_BIT] || eng_rdata[flc_pkg::EWIN_BIT]) begin
          st_d = S_IDLE; // Window closed, sector not offered
          ev[flc_pkg::ST_REJ] = 1'h1;
        end else begin
          st_d = S_EW; // Window open
        end
      end
      S_EW: if (eng_done) begin
        st_d = S_EC;
      end
      S_EC: if (eng_done) begin
        last_d = eng_rdata;
        ewin_d = eng_rdata[flc_pkg::EWIN_BIT];
        st_d = S_IDLE;
        // Flag high after the add means it may have been lost
        ev[flc_pkg::ST_REJ] = eng_rdata[flc_pkg::EWIN_BIT];
        ev[flc_pkg::ST_DONE] = ~eng_rdata[flc_pkg::EWIN_BIT];
      end
      default: st_d = S_IDLE;
    endcase
    if (eng_done) begin
      pend_d = 1'h0;
    end
  end

  // Operation sequencer, registers
  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      st_q <= S_IDLE;
      pend_q <= 1'h0;
      req_v_q <= 1'h0;
      a_q <= '0;
      b_q <= '0;
      last_q <= '0;
      ewin_q <= 1'h0;
    end else begin
      st_q <= st_d;
      pend_q <= pend_d;
      req_v_q <= req_v_d;
      a_q <= a_d;
      b_q <= b_d;
      last_q <= last_d;
      ewin_q <= ewin_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flash bus cycle engine
  flc_cycle u_cycle (
    .clk(REF_CLK),
    .rst_b(RST_B),
    .req_v(req_v_q),
    .req(req),
    .dq_i(FL_DQ_I),
    .pins(pins),
    .rdata(eng_rdata),
    .done(eng_done)
  );

  // Outputs, all from flip-flops here or in the engine
  assign AWREADY = awready_q;
  assign WREADY = awready_q;
  assign BVALID = bvalid_q;
  assign BRESP = bresp_q;
  assign ARREADY = arready_q;
  assign RVALID = rvalid_q;
  assign RRESP = rresp_q;
  assign RDATA = rdata_q;
  assign IRQ = irq_q;
  assign FL_CE_N = pins.ce_n;
  assign FL_OE_N = pins.oe_n;
  assign FL_WE_N = pins.we_n;
  assign FL_A = pins.a;
  assign FL_DQ_O = pins.dq_o;
  assign FL_DQ_OE = pins.dq_oe;

endmodule

// *** hdl/flc_pkg.sv ***
// Shared constants and carrier types for the flash status-polling controller
package flc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;
  localparam int AXI_AW = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Timing of one flash bus cycle, REF_CLK at 200 MHz
  localparam int CLK_NS = 5;
  localparam int T_SET_NS = 10;
  localparam int T_PULSE_NS = 50;
  localparam int T_HOLD_NS = 20;
  localparam int SET_CYC = (T_SET_NS + CLK_NS - 1) / CLK_NS;
  localparam int PULSE_CYC = (T_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC = (T_HOLD_NS + CLK_NS - 1) / CLK_NS;

  ////////////////////////////////////////////////////////////////////////////
  // Status bit positions on the flash data bus
  localparam int POLL_BIT = 7;
  localparam int TB1_BIT = 6;
  localparam int FAIL_BIT = 5;
  localparam int EWIN_BIT = 3;
  localparam int TB2_BIT = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets (byte addresses)
  localparam logic [AXI_AW-1:0] OFS_CTRL = 8'h00;
  localparam logic [AXI_AW-1:0] OFS_ADDR = 8'h04;
  localparam logic [AXI_AW-1:0] OFS_WDATA = 8'h08;
  localparam logic [AXI_AW-1:0] OFS_RDATA = 8'h0C;
  localparam logic [AXI_AW-1:0] OFS_STAT = 8'h10;
  localparam logic [AXI_AW-1:0] OFS_MASK = 8'h14;
  localparam logic [AXI_AW-1:0] OFS_RSTCMD = 8'h18;

  // Operation codes in CTRL[2:0]
  localparam logic [2:0] OP_WRITE = 3'h0;
  localparam logic [2:0] OP_READ = 3'h1;
  localparam logic [2:0] OP_POLL = 3'h2;
  localparam logic [2:0] OP_ERASE_ADD = 3'h3;

  // Field positions
  localparam int CTRL_BUSY_BIT = 8;
  localparam int RD_RB_BIT = 16;
  localparam int RD_EWIN_BIT = 17;
  localparam int ST_DONE = 0;
  localparam int ST_FAIL = 1;
  localparam int ST_REJ = 2;
  localparam int STAT_W = 3;

  // Reset values and bus responses
  localparam logic [DATA_W-1:0] RSTV_RSTCMD = 16'h0000;
  localparam logic [STAT_W-1:0] RSTV_MASK = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } flc_req_t;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] dq_o;
    logic dq_oe;
  } flc_pins_t;

endpackage
